/* verilog/mbpd_regs.svh */
// constants for the serial poll master with diagnostics
// Contract
// - Address 0 is broadcast, 1 to 247 pick one slave, and 248 to 255 are reserved and unused.
// - Each request carries the target slave address and the master has no address of its own.
// - Only the master starts a transaction and a slave talks only to answer a request sent to it.
// - The master keeps at most one request outstanding until a reply or a timeout.
// - A broadcast gets no reply and the master does not wait for one.
// - A response timer runs for each addressed request and on expiry the request is abandoned.
// - The master keeps polling and enters diagnostic mode after three unanswered polls in a row.
// - In diagnostic mode diagnose packets are sent repeatedly at a regular interval.
// - A correct reply in diagnostic mode ends it and normal polling resumes.
// - Byte one of a diagnose packet is the packet length.
// - Byte two is the page number and byte three the fieldbus I/O module number.
`ifndef MBPD_REGS_SVH
`define MBPD_REGS_SVH
`define MBPD_ADDR_BCAST 8'h00
`define MBPD_ADDR_MAX 8'hf7
`define MBPD_MISS_LIMIT 2'h3
`define MBPD_DIAG_LEN 8'h03
`define MBPD_CLK_HZ 25000000
`define MBPD_TIMEOUT_US 1000
`define MBPD_TIMEOUT_CYC (`MBPD_TIMEOUT_US * (`MBPD_CLK_HZ / 1000000))
`define MBPD_DIAG_PERIOD_US 100000
`define MBPD_DIAG_PERIOD_CYC (`MBPD_DIAG_PERIOD_US * (`MBPD_CLK_HZ / 1000000))
`endif

/* verilog/mbpd_pkg.sv */
// types for the serial poll master with diagnostics
package mbpd_pkg;
  typedef enum logic [1:0] {
    MBPD_IDLE,
    MBPD_WAIT,
    MBPD_DIAG
  } mbpd_state_t;
endpackage

/* verilog/mbpd_poll_master.sv */
// serial poll master: one outstanding request, timeout, diagnostic mode
`timescale 1ns/1ps
`default_nettype none
`include "mbpd_regs.svh"
module mbpd_poll_master #(
  parameter int TIMEOUT_CYC = `MBPD_TIMEOUT_CYC,
  parameter int DIAG_PERIOD_CYC = `MBPD_DIAG_PERIOD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [7:0] req_func_i,
  input wire logic [7:0] req_page_i,
  input wire logic [7:0] req_module_i,
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_addr_i,
  input wire logic rsp_ok_i,
  input wire logic rsp_exc_i,
  output logic req_ready_o,
  output logic bus_send_o,
  output logic [7:0] bus_addr_o,
  output logic [7:0] bus_func_o,
  output logic req_reject_o,
  output logic timeout_o,
  output logic rsp_done_o,
  output logic rsp_exc_o,
  output logic diag_mode_o,
  output logic diag_send_o,
  output logic [7:0] diag_len_o,
  output logic [7:0] diag_page_o,
  output logic [7:0] diag_module_o
);
  mbpd_pkg::mbpd_state_t state_q;
  logic [31:0] timer_q;
  logic [31:0] diag_tmr_q;
  logic [1:0] miss_q;
  logic [7:0] cur_addr_q;
  logic [7:0] cur_page_q;
  logic [7:0] cur_module_q;
  // valid, ok, exception and address bits of a reply
  localparam int RSP_W = 11;
  logic [RSP_W-1:0] rsp_raw;
  logic [RSP_W-1:0] rsp_s1_q;
  logic [RSP_W-1:0] rsp_s2_q;
  logic rsp_seen_q;
  logic rsp_sync;
  logic ok_sync;
  logic exc_sync;
  logic [7:0] ra_sync;
  logic rsp_evt;
  logic start;
  logic addr_legal;
  logic is_bcast;
  logic take;
  logic rsp_match;
  logic expire;

  assign rsp_raw = {rsp_valid_i, rsp_ok_i, rsp_exc_i, rsp_addr_i};

  // reply pins come from the serial receiver: two flops per bit
  for (genvar b = 0; b < RSP_W; b++) begin : g_sync
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        rsp_s1_q[b] <= 1'b0;
        rsp_s2_q[b] <= 1'b0;
      end else begin
        rsp_s1_q[b] <= rsp_raw[b];
        rsp_s2_q[b] <= rsp_s1_q[b];
      end
    end
  end

  assign {rsp_sync, ok_sync, exc_sync, ra_sync} = rsp_s2_q;

  // a held reply counts once, at its first synchronised cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_seen_q <= 1'b0;
    end else begin
      rsp_seen_q <= rsp_sync;
    end
  end
  assign rsp_evt = rsp_sync && !rsp_seen_q;

  assign is_bcast = (req_addr_i == `MBPD_ADDR_BCAST);
  assign addr_legal = (req_addr_i <= `MBPD_ADDR_MAX);
  assign take = req_valid_i && req_ready_o;
  assign start = take && addr_legal && !is_bcast;
  // a reply counts only from the polled slave while waiting
  assign rsp_match = rsp_evt && (ra_sync == cur_addr_q)
    && (state_q != mbpd_pkg::MBPD_IDLE);
  assign expire = (state_q != mbpd_pkg::MBPD_IDLE) && !rsp_match
    && (timer_q == 32'(TIMEOUT_CYC - 1));

  // response timer, runs only while a poll is outstanding
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_q <= 32'h0;
    end else if ((state_q == mbpd_pkg::MBPD_IDLE) || rsp_match || expire) begin
      timer_q <= 32'h0;
    end else begin
      timer_q <= timer_q + 32'h1;
    end
  end

  // request sequencing
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= mbpd_pkg::MBPD_IDLE;
    end else begin
      unique case (state_q)
        mbpd_pkg::MBPD_IDLE: begin
          if (start) begin
            state_q <= (miss_q == `MBPD_MISS_LIMIT) ? mbpd_pkg::MBPD_DIAG
                                                    : mbpd_pkg::MBPD_WAIT;
          end
        end
        mbpd_pkg::MBPD_WAIT, mbpd_pkg::MBPD_DIAG: begin
          if (rsp_match || expire) begin
            state_q <= mbpd_pkg::MBPD_IDLE;
          end
        end
        default: state_q <= mbpd_pkg::MBPD_IDLE;
      endcase
    end
  end

  // target of the outstanding poll, also the source of diagnose data
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_addr_q <= 8'h00;
      cur_page_q <= 8'h00;
      cur_module_q <= 8'h00;
    end else if (start) begin
      cur_addr_q <= req_addr_i;
      cur_page_q <= req_page_i;
      cur_module_q <= req_module_i;
    end
  end

  // ready only with no poll outstanding; broadcasts leave it up
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_ready_o <= 1'b0;
    end else if (state_q == mbpd_pkg::MBPD_IDLE) begin
      req_ready_o <= !start;
    end else begin
      req_ready_o <= rsp_match || expire;
    end
  end

  // request put on the bus, or refused
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_send_o <= 1'b0;
      bus_addr_o <= 8'h00;
      bus_func_o <= 8'h00;
      req_reject_o <= 1'b0;
    end else begin
      bus_send_o <= take && addr_legal;
      req_reject_o <= take && !addr_legal;
      if (take && addr_legal) begin
        bus_addr_o <= req_addr_i;
        bus_func_o <= req_func_i;
      end
    end
  end

  // outcome pulses of the outstanding poll
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_o <= 1'b0;
      rsp_done_o <= 1'b0;
      rsp_exc_o <= 1'b0;
    end else begin
      timeout_o <= expire;
      rsp_done_o <= rsp_match;
      rsp_exc_o <= rsp_match && exc_sync;
    end
  end

  // consecutive miss counter and diagnostic mode
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miss_q <= 2'h0;
      diag_mode_o <= 1'b0;
    end else begin
      if (rsp_match && (ok_sync || exc_sync)) begin
        miss_q <= 2'h0;
        diag_mode_o <= 1'b0;
      end else if (expire) begin
        if (miss_q != `MBPD_MISS_LIMIT) begin
          miss_q <= miss_q + 2'h1;
        end
        if (miss_q == (`MBPD_MISS_LIMIT - 2'h1)) begin
          diag_mode_o <= 1'b1;
        end
      end
    end
  end

  // periodic diagnose packets
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      diag_tmr_q <= 32'h0;
      diag_send_o <= 1'b0;
      diag_len_o <= 8'h00;
      diag_page_o <= 8'h00;
      diag_module_o <= 8'h00;
    end else begin
      diag_send_o <= 1'b0;
      if (!diag_mode_o) begin
        diag_tmr_q <= 32'h0;
      end else if (diag_tmr_q == 32'h0) begin
        diag_send_o <= 1'b1;
        diag_len_o <= `MBPD_DIAG_LEN;
        diag_page_o <= cur_page_q + 8'h01;
        diag_module_o <= cur_module_q + 8'h01;
        diag_tmr_q <= 32'(DIAG_PERIOD_CYC - 1);
      end else begin
        diag_tmr_q <= diag_tmr_q - 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/mbpd_poll_master_asserts.sv */
// checker for the serial poll master
`timescale 1ns/1ps
`default_nettype none
module mbpd_poll_master_asserts #(parameter int TIMEOUT_CYC = 20) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic bus_send_o,
  input wire logic req_reject_o,
  input wire logic timeout_o,
  input wire logic rsp_valid_i,
  input wire logic rsp_done_o,
  input wire logic rsp_exc_o,
  input wire logic diag_mode_o,
  input wire logic diag_send_o,
  input wire logic [7:0] req_addr_i,
  input wire logic [7:0] bus_addr_o,
  input wire logic [7:0] diag_len_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_take; req_valid_i && req_ready_o; endsequence
  sequence s_diag; timeout_o ##1 (diag_send_o && diag_len_o == 8'h03); endsequence
  a_send_legal: assert property (s_take ##0 req_addr_i < 8'hf8 |=>
    bus_send_o && bus_addr_o == $past(req_addr_i)) else $error("no send");
  a_refuse_reserved: assert property (s_take ##0 req_addr_i > 8'hf7 |=>
    req_reject_o && !bus_send_o) else $error("no refusal");
  a_one_pending: assert property (bus_send_o && bus_addr_o != 8'h00 |-> !req_ready_o)
    else $error("ready while pending");
  a_bcast_free: assert property (bus_send_o && bus_addr_o == 8'h00 |-> req_ready_o)
    else $error("broadcast waits");
  a_timeout_late: assert property (timeout_o |-> $past(bus_send_o, TIMEOUT_CYC) && req_ready_o)
    else $error("bad timeout");
  a_done_cause: assert property (rsp_done_o |-> $past(rsp_valid_i, 3) && req_ready_o)
    else $error("bad done");
  a_diag_entry: assert property ($rose(diag_mode_o) |-> s_diag)
    else $error("bad diag entry");
  a_diag_leave: assert property (rsp_done_o |-> ##[0:1] !diag_mode_o)
    else $error("diag kept");
  a_exc_pair: assert property (rsp_exc_o |-> rsp_done_o)
    else $error("exception without done");
endmodule
bind mbpd_poll_master mbpd_poll_master_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC))
  mbpd_poll_master_asserts_i (
  .sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i),
  .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o),
  .bus_send_o(bus_send_o),
  .req_reject_o(req_reject_o),
  .timeout_o(timeout_o),
  .rsp_valid_i(rsp_valid_i),
  .rsp_done_o(rsp_done_o),
  .rsp_exc_o(rsp_exc_o),
  .diag_mode_o(diag_mode_o),
  .diag_send_o(diag_send_o),
  .req_addr_i(req_addr_i),
  .bus_addr_o(bus_addr_o),
  .diag_len_o(diag_len_o)
);
`default_nettype wire

/* verif/mbpd_slave_model.sv */
// serial slave stand-in answering addressed polls
`timescale 1ns/1ps
`default_nettype none
module mbpd_slave_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic send_i,
  input wire logic mute_i,
  input wire logic exc_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wait_i,
  output logic valid_o,
  output logic ok_o,
  output logic exc_o,
  output logic [7:0] addr_o
);
  logic [8:0] cnt_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {cnt_q, valid_o, ok_o, exc_o, addr_o} <= '0;
    end else begin
      if (send_i && addr_i != 8'h00 && !mute_i) cnt_q <= {1'b0, wait_i} + 9'h2;
      else if (cnt_q != 9'h0) cnt_q <= cnt_q - 9'h1;
      valid_o <= cnt_q == 9'h2 || cnt_q == 9'h1;
      if (cnt_q == 9'h2) {addr_o, ok_o, exc_o} <= {addr_i, !exc_i, exc_i};
      else if (cnt_q == 9'h0) {addr_o, ok_o, exc_o} <= ~{addr_o, ok_o, exc_o};
    end
  end
endmodule
`default_nettype wire

/* verif/mbpd_poll_master_tb.sv */
// bench for the serial poll master
`timescale 1ns/1ps
`default_nettype none
module mbpd_poll_master_tb;
  logic sys_clk_i = 0, resetn_i = 0, req_valid_i = 0, mute = 1, exc = 0;
  logic [7:0] req_addr_i = 0, req_func_i = 0, req_page_i = 0, req_module_i = 0, wt = 0;
  logic rsp_valid_i, rsp_ok_i, rsp_exc_i, req_ready_o, bus_send_o, req_reject_o, timeout_o;
  logic rsp_done_o, rsp_exc_o, diag_mode_o, diag_send_o, t, d, x, r, s;
  logic [7:0] rsp_addr_i, bus_addr_o, bus_func_o, diag_len_o, diag_page_o, diag_module_o;
  int bad_count = 0, tests_run = 0, cyc = 0, miss = 0, seed = 32'h1f0a, n;
  int where_q[$];
  mbpd_poll_master #(.TIMEOUT_CYC(20), .DIAG_PERIOD_CYC(50)) mbpd_poll_master_i (.*);
  mbpd_slave_model mbpd_slave_model_i (.clk_i(sys_clk_i), .resetn_i, .send_i(bus_send_o),
    .addr_i(bus_addr_o), .mute_i(mute), .exc_i(exc), .wait_i(wt), .valid_o(rsp_valid_i),
    .ok_o(rsp_ok_i), .exc_o(rsp_exc_i), .addr_o(rsp_addr_i));
  initial forever #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (++cyc > 3000) begin
    bad_count++;
    stop_test;
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic poll(input logic [7:0] a);
    {t, d, x, r, s} = '0;
    @(posedge sys_clk_i);
    req_valid_i <= 1;
    req_addr_i <= a;
    {req_page_i, req_module_i, req_func_i, wt} <=
      {24'($random(seed)), 8'($unsigned($random(seed)) % 6)};
    exc <= 1'($random(seed));
    @(posedge sys_clk_i);
    req_valid_i <= 0;
    for (n = 0; n < 60 && !(t | d | r | (s && a == 0)); n++) begin
      #1;
      {t, d, x, r, s} = {t, d, x, r, s} | {timeout_o, rsp_done_o, rsp_exc_o, req_reject_o, bus_send_o};
      @(posedge sys_clk_i);
    end
    #1;
    if (a > 247) check("reject", {r, s}, 2'b10);
    else if (a == 0) check("bcast", {s, req_ready_o}, 2'b11);
    else begin
      check("addr", bus_addr_o, a);
      check("func", bus_func_o, req_func_i);
      where_q.push_back({req_page_i + 8'h1, req_module_i + 8'h1});
      check("reply", {t, d, x}, mute ? 3'b100 : {2'b01, exc});
      miss = mute ? miss + 1 : 0;
    end
    tick;
    tick;
    check("idle", {req_ready_o, diag_mode_o}, {1'b1, miss > 2});
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1;
    mute <= 0;
    repeat (8) poll(8'($unsigned($random(seed)) % 247 + 1));
    for (int i = 247; i < 257; i++) poll(8'(i));
    $display("test basic done");
    mute <= 1;
    repeat (2) poll(8'h11);
    mute <= 0;
    poll(8'h11);
    mute <= 1;
    repeat (3) poll(8'h11);
    n = 0;
    while (diag_send_o !== 1'b1 && n++ < 60) tick;
    check("len", diag_len_o, 3);
    check("where", {diag_page_o, diag_module_o}, where_q[where_q.size() - 1]);
    n = 0;
    do begin
      tick;
      n++;
    end while (diag_send_o !== 1'b1 && n < 60);
    check("period", n, 50);
    mute <= 0;
    poll(8'h11);
    $display("test diag done");
    stop_test;
  end
endmodule
`default_nettype wire
